// File: core/core_exec_pkg.sv
// shared constants and types for the core compare and core management slice
package core_exec_pkg;
	// opcode fields
	localparam int INSTR_HI = 31;
	localparam int INSTR_LO = 26;
	localparam int EFF_Z = 25;
	localparam int EFF_C = 24;
	localparam int EFF_R = 23;
	localparam int EFF_I = 22;
	localparam int COND_HI = 21;
	localparam int COND_LO = 18;
	localparam int DEST_HI = 17;
	localparam int DEST_LO = 9;
	localparam int SRC_HI = 8;
	localparam int SRC_LO = 0;
	// instruction codes
	localparam logic [5:0] OP_HUB = 6'h03;
	localparam logic [5:0] OP_PLAIN_UCMP = 6'h21;
	localparam logic [5:0] OP_EXT_UCMP = 6'h33;
	localparam logic [5:0] OP_EXT_SCMP = 6'h31;
	localparam logic [2:0] HUB_OWN_ID = 3'h1;
	localparam logic [2:0] HUB_START = 3'h2;
	localparam logic [2:0] HUB_HALT = 3'h3;
	localparam logic [3:0] COND_ALWAYS = 4'hf;
	// core start operand fields
	localparam int PARAM_HI = 31;
	localparam int PARAM_LO = 18;
	localparam int CODE_HI = 17;
	localparam int CODE_LO = 4;
	localparam int NEW_BIT = 3;
	localparam int ID_HI = 2;
	localparam int PAR_LO = 2;
	// timing in clocks
	localparam logic [4:0] EXEC_CLOCKS = 5'h04;
	localparam logic [4:0] HUB_MIN_CLOCKS = 5'h07;
	localparam logic [4:0] HUB_MAX_CLOCKS = 5'h16;
	// local memory of a started core
	localparam logic [8:0] FIRST_REG = 9'h000;
	localparam logic [8:0] LAST_GENERAL_REG = 9'h1ef;
	// reset and fallback values
	localparam logic [7:0] CORE_ACTIVE_RESET = 8'h01;
	localparam logic [2:0] NO_FREE_ID = 3'h7;
	typedef enum {ST_IDLE, ST_RUN} exec_state_type;
	typedef enum {OPK_UCMP, OPK_XUCMP, OPK_XSCMP, OPK_OWN_ID, OPK_START, OPK_HALT,
		OPK_OTHER} op_kind_type;
endpackage : core_exec_pkg

// File: core/ext_compare_unit.sv
// plain and extended compare arithmetic, signed or unsigned
`timescale 1ns/1ps
`default_nettype none
module ext_compare_unit (
	input wire logic [31:0] destVal,
	input wire logic [31:0] srcVal,
	input wire logic carryIn,
	input wire logic zeroIn,
	input wire logic extended,
	input wire logic signedCmp,
	output logic zeroOut,
	output logic carryOut
);
	logic [33:0] destExt;
	logic [33:0] srcExt;
	logic [33:0] diff;

	always_comb begin
		destExt = signedCmp ? {destVal[31], destVal[31], destVal} : {2'b00, destVal};
		srcExt = signedCmp ? {srcVal[31], srcVal[31], srcVal} : {2'b00, srcVal};
		// 34 bits so that source plus carry never wraps
		diff = destExt - srcExt - {33'h0, extended & carryIn};
		carryOut = diff[33];
		// chained zero only survives if every earlier word was equal
		zeroOut = extended ? (zeroIn & (diff == 34'h0)) : (diff == 34'h0);
	end
endmodule : ext_compare_unit
`default_nettype wire

// File: core/core_exec_slice.sv
// instruction sequencing for extended compares, core management and conditions
//
// What this block does
// - extended unsigned compare, destination unwritten, four clocks
// - unsigned chained zero; carry on multi-word below
// - extended signed compare, destination unwritten, four clocks
// - signed chained zero; carry on signed below
// - own number written; zero when number zero
// - hub instructions take seven to twenty-two clocks; a start waits longer while a launch is loading
// - start operand: parameter, code, free bit, number
// - parameter register bits 15:2 get field, rest zero
// - target loads registers, clears specials, runs at zero
// - free bit starts lowest inactive core
// - otherwise named core starts or restarts
// - start zero on core zero, carry when none
// - start writes chosen core number when requested
// - halt gates clock of named core
// - every instruction has four-bit condition field
// - false condition is four-clock no-op
// - carry kept unless carry write requested
// - condition bit indexed by carry and zero
// - opcode effect bits decide flag and destination writes
`timescale 1ns/1ps
`default_nettype none
module core_exec_slice (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] coreNumber,
	input wire logic instrValid,
	input wire logic [31:0] instrWord,
	input wire logic [31:0] destValue,
	input wire logic [31:0] srcValue,
	output logic instrReady,
	output logic retire,
	output logic zeroFlag,
	output logic carryFlag,
	output logic destWe,
	output logic [8:0] destIdx,
	output logic [31:0] destData,
	output logic [7:0] coreClockEnable,
	output logic startValid,
	output logic [2:0] startCore,
	output logic [31:0] startParam,
	output logic loadValid,
	output logic [2:0] loadCore,
	output logic [8:0] loadCogAddr,
	output logic [15:0] loadHubAddr,
	output logic specialClear,
	output logic runStart,
	output logic [8:0] runPc
);
	core_exec_pkg::exec_state_type state_reg;
	core_exec_pkg::op_kind_type kind_reg;
	core_exec_pkg::op_kind_type kindNext;
	logic condOk_reg;
	logic wz_reg;
	logic wc_reg;
	logic wr_reg;
	logic [31:0] dVal_reg;
	logic [31:0] sVal_reg;
	logic [4:0] elapsed_reg;
	logic [3:0] hubPhase_reg;
	logic [7:0] coreActive_reg;
	logic loadBusy_reg;
	logic [8:0] loadIdx_reg;
	logic [15:0] loadBase_reg;
	logic accept;
	logic finish;
	logic slotMine;
	logic condPass;
	logic cmpZero;
	logic cmpCarry;
	logic [2:0] startTarget;
	logic startAvail;
	logic [31:0] srcOperand;

	function automatic core_exec_pkg::op_kind_type decodeKind(input logic [31:0] w);
		core_exec_pkg::op_kind_type k;
		k = core_exec_pkg::OPK_OTHER;
		if (w[core_exec_pkg::INSTR_HI:core_exec_pkg::INSTR_LO] == core_exec_pkg::OP_PLAIN_UCMP)
			k = core_exec_pkg::OPK_UCMP;
		else if (w[core_exec_pkg::INSTR_HI:core_exec_pkg::INSTR_LO] == core_exec_pkg::OP_EXT_UCMP)
			k = core_exec_pkg::OPK_XUCMP;
		else if (w[core_exec_pkg::INSTR_HI:core_exec_pkg::INSTR_LO] == core_exec_pkg::OP_EXT_SCMP)
			k = core_exec_pkg::OPK_XSCMP;
		else if (w[core_exec_pkg::INSTR_HI:core_exec_pkg::INSTR_LO] == core_exec_pkg::OP_HUB) begin
			if (w[2:0] == core_exec_pkg::HUB_OWN_ID)
				k = core_exec_pkg::OPK_OWN_ID;
			else if (w[2:0] == core_exec_pkg::HUB_START)
				k = core_exec_pkg::OPK_START;
			else if (w[2:0] == core_exec_pkg::HUB_HALT)
				k = core_exec_pkg::OPK_HALT;
		end
		return k;
	endfunction : decodeKind

	function automatic logic isHubKind(input core_exec_pkg::op_kind_type k);
		return (k == core_exec_pkg::OPK_OWN_ID) || (k == core_exec_pkg::OPK_START) ||
			(k == core_exec_pkg::OPK_HALT);
	endfunction : isHubKind

	function automatic logic [2:0] lowestFree(input logic [7:0] active);
		logic [2:0] id;
		id = core_exec_pkg::NO_FREE_ID;
		for (int i = 7; i >= 0; i--) begin
			if (!active[i])
				id = 3'(i);
		end
		return id;
	endfunction : lowestFree

	// a new instruction is only taken when nothing is in flight
	assign instrReady = (state_reg == core_exec_pkg::ST_IDLE);
	assign accept = instrValid && instrReady;
	assign kindNext = decodeKind(instrWord);
	// truth table lookup: carry is the upper index bit, zero the lower
	assign condPass = instrWord[core_exec_pkg::COND_LO + {carryFlag, zeroFlag}];
	assign srcOperand = instrWord[core_exec_pkg::EFF_I] ?
		{23'h0, instrWord[core_exec_pkg::SRC_HI:core_exec_pkg::SRC_LO]} : srcValue;
	assign slotMine = (hubPhase_reg == {coreNumber, 1'b0});

	// a false condition turns a hub op into a plain four-clock no-op
	always_comb begin
		finish = 1'b0;
		if (state_reg == core_exec_pkg::ST_RUN) begin
			if (condOk_reg && isHubKind(kind_reg))
				// a start also waits for a previous launch to finish loading
				finish = (elapsed_reg >= core_exec_pkg::HUB_MIN_CLOCKS) && slotMine &&
					!((kind_reg == core_exec_pkg::OPK_START) && loadBusy_reg);
			else
				finish = (elapsed_reg == core_exec_pkg::EXEC_CLOCKS);
		end
	end

	ext_compare_unit cmpUnit (
		.destVal(dVal_reg),
		.srcVal(sVal_reg),
		.carryIn(carryFlag),
		.zeroIn(zeroFlag),
		.extended(kind_reg != core_exec_pkg::OPK_UCMP),
		.signedCmp(kind_reg == core_exec_pkg::OPK_XSCMP),
		.zeroOut(cmpZero),
		.carryOut(cmpCarry)
	);

	always_comb begin
		if (dVal_reg[core_exec_pkg::NEW_BIT]) begin
			startTarget = lowestFree(coreActive_reg);
			startAvail = ~&coreActive_reg;
		end else begin
			startTarget = dVal_reg[core_exec_pkg::ID_HI:0];
			startAvail = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			state_reg <= core_exec_pkg::ST_IDLE;
		else if (accept)
			state_reg <= core_exec_pkg::ST_RUN;
		else if (finish)
			state_reg <= core_exec_pkg::ST_IDLE;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			elapsed_reg <= 5'h00;
		else if (accept)
			elapsed_reg <= 5'h01;
		else if ((state_reg == core_exec_pkg::ST_RUN) && (elapsed_reg != 5'h1f))
			elapsed_reg <= elapsed_reg + 5'h01;
	end

	// hub rotation: one window per core every sixteen clocks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			hubPhase_reg <= 4'h0;
		else
			hubPhase_reg <= hubPhase_reg + 4'h1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			kind_reg <= core_exec_pkg::OPK_OTHER;
			condOk_reg <= 1'b0;
			wz_reg <= 1'b0;
			wc_reg <= 1'b0;
			wr_reg <= 1'b0;
			dVal_reg <= 32'h0;
			sVal_reg <= 32'h0;
			destIdx <= 9'h000;
		end else if (accept) begin
			kind_reg <= kindNext;
			condOk_reg <= condPass;
			// effect bits arrive already merged with any explicit effects
			wz_reg <= instrWord[core_exec_pkg::EFF_Z];
			wc_reg <= instrWord[core_exec_pkg::EFF_C];
			wr_reg <= instrWord[core_exec_pkg::EFF_R];
			dVal_reg <= destValue;
			sVal_reg <= srcOperand;
			destIdx <= instrWord[core_exec_pkg::DEST_HI:core_exec_pkg::DEST_LO];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			zeroFlag <= 1'b0;
		else if (finish && condOk_reg && wz_reg) begin
			unique case (kind_reg)
				core_exec_pkg::OPK_UCMP,
				core_exec_pkg::OPK_XUCMP,
				core_exec_pkg::OPK_XSCMP: zeroFlag <= cmpZero;
				core_exec_pkg::OPK_OWN_ID: zeroFlag <= (coreNumber == 3'h0);
				core_exec_pkg::OPK_START: zeroFlag <= (startTarget == 3'h0);
				core_exec_pkg::OPK_HALT,
				core_exec_pkg::OPK_OTHER: zeroFlag <= zeroFlag;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			carryFlag <= 1'b0;
		else if (finish && condOk_reg && wc_reg) begin
			unique case (kind_reg)
				core_exec_pkg::OPK_UCMP,
				core_exec_pkg::OPK_XUCMP,
				core_exec_pkg::OPK_XSCMP: carryFlag <= cmpCarry;
				core_exec_pkg::OPK_START: carryFlag <= !startAvail;
				core_exec_pkg::OPK_OWN_ID,
				core_exec_pkg::OPK_HALT,
				core_exec_pkg::OPK_OTHER: carryFlag <= carryFlag;
			endcase
		end
	end

	// compares and halt never write back, whatever the effect bits say
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			destWe <= 1'b0;
			destData <= 32'h0;
			retire <= 1'b0;
		end else begin
			retire <= finish;
			destWe <= 1'b0;
			if (finish && condOk_reg && wr_reg) begin
				if (kind_reg == core_exec_pkg::OPK_OWN_ID) begin
					destWe <= 1'b1;
					destData <= {29'h0, coreNumber};
				end else if (kind_reg == core_exec_pkg::OPK_START) begin
					destWe <= 1'b1;
					destData <= {29'h0, startTarget};
				end
			end
		end
	end

	// core activity doubles as the clock gate of each core
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			coreActive_reg <= core_exec_pkg::CORE_ACTIVE_RESET;
		else if (finish && condOk_reg && (kind_reg == core_exec_pkg::OPK_START) && startAvail)
			coreActive_reg[startTarget] <= 1'b1;
		else if (finish && condOk_reg && (kind_reg == core_exec_pkg::OPK_HALT))
			coreActive_reg[dVal_reg[core_exec_pkg::ID_HI:0]] <= 1'b0;
	end
	assign coreClockEnable = coreActive_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			startValid <= 1'b0;
			startCore <= 3'h0;
			startParam <= 32'h0;
		end else begin
			startValid <= 1'b0;
			if (finish && condOk_reg && (kind_reg == core_exec_pkg::OPK_START) && startAvail) begin
				startValid <= 1'b1;
				startCore <= startTarget;
				startParam <= {16'h0, dVal_reg[core_exec_pkg::PARAM_HI:core_exec_pkg::PARAM_LO],
					2'b00};
			end
		end
	end

	// loader streams one local register per clock, then clears specials and runs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			loadBusy_reg <= 1'b0;
			loadIdx_reg <= core_exec_pkg::FIRST_REG;
			loadBase_reg <= 16'h0;
			loadCore <= 3'h0;
		end else if (finish && condOk_reg && (kind_reg == core_exec_pkg::OPK_START) &&
			startAvail) begin
			loadBusy_reg <= 1'b1;
			loadIdx_reg <= core_exec_pkg::FIRST_REG;
			loadBase_reg <= {dVal_reg[core_exec_pkg::CODE_HI:core_exec_pkg::CODE_LO],
				2'b00};
			loadCore <= startTarget;
		end else if (finish && condOk_reg && (kind_reg == core_exec_pkg::OPK_HALT) &&
			(dVal_reg[core_exec_pkg::ID_HI:0] == loadCore)) begin
			// halting the core being loaded abandons its launch
			loadBusy_reg <= 1'b0;
		end else if (loadBusy_reg) begin
			if (loadIdx_reg == core_exec_pkg::LAST_GENERAL_REG)
				loadBusy_reg <= 1'b0;
			else
				loadIdx_reg <= loadIdx_reg + 9'h001;
		end
	end
	assign loadValid = loadBusy_reg;
	assign loadCogAddr = loadIdx_reg;
	assign loadHubAddr = loadBase_reg + {5'h00, loadIdx_reg, 2'b00};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			specialClear <= 1'b0;
			runStart <= 1'b0;
		end else begin
			specialClear <= loadBusy_reg && (loadIdx_reg == core_exec_pkg::LAST_GENERAL_REG);
			runStart <= loadBusy_reg && (loadIdx_reg == core_exec_pkg::LAST_GENERAL_REG);
		end
	end
	assign runPc = core_exec_pkg::FIRST_REG;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_cmp_four;
		accept && (kindNext == core_exec_pkg::OPK_XUCMP || kindNext == core_exec_pkg::OPK_XSCMP)
			|-> !finish[*4] ##1 finish;
	endproperty
	a_cmp_four: assert property (p_cmp_four) else $error("compare not four clocks");

	property p_cmp_no_write;
		finish && (kind_reg == core_exec_pkg::OPK_XSCMP || kind_reg == core_exec_pkg::OPK_XUCMP)
			|=> !destWe;
	endproperty
	a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare wrote dest");

	property p_chain_zero;
		finish && condOk_reg && wz_reg && (kind_reg == core_exec_pkg::OPK_XUCMP) && !zeroFlag
			|=> !zeroFlag;
	endproperty
	a_chain_zero: assert property (p_chain_zero) else $error("chained zero revived");

	property p_hub_min;
		accept && isHubKind(kindNext) && condPass |=> !finish[*6];
	endproperty
	a_hub_min: assert property (p_hub_min) else $error("hub op too fast");

	property p_hub_max;
		accept && condPass && (kindNext == core_exec_pkg::OPK_OWN_ID ||
			kindNext == core_exec_pkg::OPK_HALT) |-> ##[7:22] finish;
	endproperty
	a_hub_max: assert property (p_hub_max) else $error("hub op too slow");

	property p_false_nop;
		finish && !condOk_reg |=> $stable(zeroFlag) && $stable(carryFlag) && !destWe &&
			$stable(coreActive_reg);
	endproperty
	a_false_nop: assert property (p_false_nop) else $error("false condition had effect");

	property p_carry_hold;
		finish && !wc_reg |=> $stable(carryFlag);
	endproperty
	a_carry_hold: assert property (p_carry_hold) else $error("carry changed");

	property p_own_id;
		finish && condOk_reg && wr_reg && (kind_reg == core_exec_pkg::OPK_OWN_ID)
			|=> destWe && (destData == {29'h0, $past(coreNumber)});
	endproperty
	a_own_id: assert property (p_own_id) else $error("own number wrong");

	property p_halt;
		finish && condOk_reg && (kind_reg == core_exec_pkg::OPK_HALT)
			|=> !coreClockEnable[$past(dVal_reg[2:0])];
	endproperty
	a_halt: assert property (p_halt) else $error("halted core still clocked");

	property p_stall;
		(state_reg == core_exec_pkg::ST_RUN) && !finish |=> !instrReady;
	endproperty
	a_stall: assert property (p_stall) else $error("ready while busy");

	// launch length counted here, far too long to unroll as a delay
	logic [9:0] loadSpan_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			loadSpan_reg <= 10'h000;
		else if (startValid)
			loadSpan_reg <= 10'h001;
		else if (loadValid)
			loadSpan_reg <= loadSpan_reg + 10'h001;
	end

	property p_load_run;
		(startValid |-> loadValid) and
			(runStart |-> (loadSpan_reg == {1'b0, core_exec_pkg::LAST_GENERAL_REG} + 10'h001));
	endproperty
	a_load_run: assert property (p_load_run) else $error("launch sequence wrong");

	c_start: cover property (startValid);
	c_false: cover property (finish && !condOk_reg);
	c_hub_late: cover property (finish && isHubKind(kind_reg) && elapsed_reg == 5'h16);
	c_chain: cover property (finish && kind_reg == core_exec_pkg::OPK_XSCMP && wc_reg);
endmodule : core_exec_slice
`default_nettype wire

// File: bench/core_hub_model.sv
// behavioural model of the cores side that takes start-up loads
`timescale 1ns/1ps
`default_nettype none
module core_hub_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic loadValid,
	input wire logic [8:0] loadCogAddr,
	input wire logic [15:0] loadHubAddr,
	input wire logic specialClear,
	input wire logic runStart,
	input wire logic [8:0] runPc,
	output int modelErrs,
	output int loadsDone,
	output logic [15:0] firstHubAddr
);
	logic [9:0] wordIdx_reg;
	logic [15:0] prevHub_reg;
	logic badWord;
	logic badRun;
	// a skipped or repeated word would leave a hole in the started program
	assign badWord = loadValid && ((loadCogAddr !== wordIdx_reg[8:0]) || (wordIdx_reg > 10'h1ef)
		|| ((wordIdx_reg != 10'h000) && (loadHubAddr !== prevHub_reg + 16'h0004)));
	assign badRun = (specialClear || runStart) && (!(specialClear && runStart)
		|| (wordIdx_reg !== 10'h1f0) || (runPc !== 9'h000));
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wordIdx_reg <= 10'h000;
			prevHub_reg <= 16'h0000;
			modelErrs <= 0;
			loadsDone <= 0;
			firstHubAddr <= 16'h0000;
		end else begin
			if (badWord || badRun) begin
				modelErrs <= modelErrs + 1;
			end
			if (loadValid) begin
				if (wordIdx_reg == 10'h000) begin
					firstHubAddr <= loadHubAddr;
				end
				prevHub_reg <= loadHubAddr;
				wordIdx_reg <= wordIdx_reg + 10'h001;
			end
			if (specialClear || runStart) begin
				loadsDone <= loadsDone + 1;
				wordIdx_reg <= 10'h000;
			end
		end
	end
endmodule : core_hub_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the core execution slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [5:0] op;
		logic [31:0] d;
		logic [31:0] s;
		logic z;
		logic c;
	} cmp_row_type;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] coreNumber = 3'h0;
	logic instrValid = 1'b0;
	logic [31:0] instrWord = 32'h0;
	logic [31:0] destValue = 32'h0;
	logic [31:0] srcValue = 32'h0;
	logic instrReady, retire, zeroFlag, carryFlag, destWe, startValid, loadValid;
	logic specialClear, runStart, weSeen, svSeen, ex;
	logic [8:0] destIdx, loadCogAddr, runPc;
	logic [31:0] destData, startParam, dataSeen;
	logic [7:0] coreClockEnable;
	logic [2:0] startCore, loadCore;
	logic [15:0] loadHubAddr, firstHubAddr;
	logic [3:0] cv;
	logic [1:0] expF;
	int modelErrs, loadsDone, errTotal, nTests, cyc, idx;
	cmp_row_type rows [16];

	core_exec_slice i_dut (.clk, .arst_n, .coreNumber, .instrValid, .instrWord, .destValue,
		.srcValue, .instrReady, .retire, .zeroFlag, .carryFlag, .destWe, .destIdx, .destData,
		.coreClockEnable, .startValid, .startCore, .startParam, .loadValid, .loadCore,
		.loadCogAddr, .loadHubAddr, .specialClear, .runStart, .runPc);
	core_hub_model i_model (.clk, .arst_n, .loadValid, .loadCogAddr, .loadHubAddr,
		.specialClear, .runStart, .runPc, .modelErrs, .loadsDone, .firstHubAddr);

	initial begin
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] mk(input logic [5:0] op, input logic [3:0] eff,
		input logic [3:0] cond, input logic [8:0] src);
		return {op, eff, cond, 9'h005, src};
	endfunction : mk

	// code image at long 0x0040 holds native code only
	function automatic logic [31:0] opnd(input logic free, input logic [2:0] id);
		return {14'h1234, 14'h0040, free, id};
	endfunction : opnd

	task automatic conclude;
		if (errTotal == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	task automatic fail;
		errTotal++;
		conclude();
	endtask : fail

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		nTests++;
		if (seen !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
			errTotal++;
		end
	endtask : check

	task automatic issue(input logic [31:0] w, input logic [31:0] d, input logic [31:0] s);
		int k;
		instrWord = w;
		destValue = d;
		srcValue = s;
		instrValid = 1'b1;
		k = 0;
		while (instrReady !== 1'b1) begin
			@(posedge clk);
			#1;
			k++;
			if (k > 50) fail();
		end
		@(posedge clk);
		#1;
		instrValid = 1'b0;
		cyc = 0;
		// hub operations stall the sequencer, so the bound covers the slowest window
		while (retire !== 1'b1) begin
			@(posedge clk);
			#1;
			cyc++;
			if (cyc > 600) fail();
		end
		weSeen = destWe;
		dataSeen = destData;
		svSeen = startValid;
	endtask : issue

	task automatic launch(input logic [31:0] d, input logic [2:0] id, input logic z, input logic c);
		int k;
		issue(mk(core_exec_pkg::OP_HUB, 4'hf, core_exec_pkg::COND_ALWAYS,
			{6'h0, core_exec_pkg::HUB_START}), d, 32'h0);
		check("start result", {weSeen, dataSeen}, {1'b1, 29'h0, id});
		check("start flags", {zeroFlag, carryFlag, svSeen}, {z, c, ~c});
		check("start clocks", (cyc >= 7 && cyc <= 22), 1);
		if (!c) begin
			check("start target", {startCore, startParam}, {id, 16'h0, 14'h1234, 2'b00});
			check("load core", loadCore, id);
			k = 0;
			while (loadValid !== 1'b0) begin
				@(posedge clk);
				#1;
				k++;
				if (k > 600) fail();
			end
			@(posedge clk);
			#1;
			check("load base", firstHubAddr, 16'h0100);
		end
	endtask : launch

	task automatic halt(input logic [2:0] id, input logic [7:0] en);
		issue(mk(core_exec_pkg::OP_HUB, 4'h1, core_exec_pkg::COND_ALWAYS,
			{6'h0, core_exec_pkg::HUB_HALT}), {29'h0, id}, 32'h0);
		@(posedge clk);
		#1;
		check("halt", {weSeen, coreClockEnable}, {1'b0, en});
		check("halt clocks", (cyc >= 7 && cyc <= 22), 1);
	endtask : halt

	initial begin
		rows = '{'{core_exec_pkg::OP_PLAIN_UCMP, 32'h5, 32'h5, 1'b1, 1'b0},
			'{core_exec_pkg::OP_EXT_UCMP, 32'h5, 32'h5, 1'b1, 1'b0},
			'{core_exec_pkg::OP_EXT_UCMP, 32'h4, 32'h5, 1'b0, 1'b1},
			'{core_exec_pkg::OP_EXT_UCMP, 32'h6, 32'h5, 1'b0, 1'b0},
			'{core_exec_pkg::OP_PLAIN_UCMP, 32'h0, 32'h1, 1'b0, 1'b1},
			'{core_exec_pkg::OP_EXT_UCMP, 32'hffffffff, 32'hffffffff, 1'b0, 1'b1},
			'{core_exec_pkg::OP_PLAIN_UCMP, 32'h1, 32'h1, 1'b1, 1'b0},
			'{core_exec_pkg::OP_EXT_SCMP, 32'hffffffff, 32'h0, 1'b0, 1'b1},
			'{core_exec_pkg::OP_PLAIN_UCMP, 32'h2, 32'h2, 1'b1, 1'b0},
			'{core_exec_pkg::OP_EXT_SCMP, 32'h0, 32'hffffffff, 1'b0, 1'b0},
			'{core_exec_pkg::OP_PLAIN_UCMP, 32'h3, 32'h3, 1'b1, 1'b0},
			'{core_exec_pkg::OP_EXT_SCMP, 32'h7, 32'h7, 1'b1, 1'b0},
			'{core_exec_pkg::OP_PLAIN_UCMP, 32'h0, 32'h1, 1'b0, 1'b1},
			'{core_exec_pkg::OP_EXT_SCMP, 32'h80000000, 32'h7fffffff, 1'b0, 1'b1},
			'{core_exec_pkg::OP_PLAIN_UCMP, 32'h0, 32'h1, 1'b0, 1'b1},
			'{core_exec_pkg::OP_EXT_UCMP, 32'h7, 32'h6, 1'b0, 1'b0}};
		repeat (5) @(posedge clk);
		#1;
		arst_n = 1'b1;
		check("reset state", {zeroFlag, carryFlag, instrReady, loadValid, coreClockEnable}, 12'h201);
		// rows chain through the flags: plain low word, then extended words
		foreach (rows[i]) begin
			issue(mk(rows[i].op, 4'he, core_exec_pkg::COND_ALWAYS, 9'h0), rows[i].d, rows[i].s);
			check("cmp flags", {zeroFlag, carryFlag}, {rows[i].z, rows[i].c});
			check("cmp write and clocks", {weSeen, cyc}, {1'b0, 32'h4});
		end
		for (int p = 0; p < 3; p++) begin
			for (int cd = 0; cd < 16; cd++) begin
				cv = cd[3:0];
				issue(mk(core_exec_pkg::OP_PLAIN_UCMP, 4'he, core_exec_pkg::COND_ALWAYS, 9'h0),
					(p == 0) ? 32'h1 : ((p == 1) ? 32'h0 : 32'h2), 32'h1);
				idx = (p == 0) ? 1 : ((p == 1) ? 2 : 0);
				ex = cv[idx];
				expF = ex ? ((p == 0) ? 2'b01 : 2'b10) : ((p == 0) ? 2'b10 : ((p == 1) ? 2'b01 : 2'b00));
				issue(mk(core_exec_pkg::OP_PLAIN_UCMP, 4'he, cv, 9'h0), (p == 0) ? 32'h0 : 32'h1, 32'h1);
				check("cond flags", {zeroFlag, carryFlag}, expF);
				check("cond clocks", cyc, 4);
			end
		end
		issue(mk(core_exec_pkg::OP_PLAIN_UCMP, 4'he, core_exec_pkg::COND_ALWAYS, 9'h0), 32'h0, 32'h1);
		issue(mk(core_exec_pkg::OP_PLAIN_UCMP, 4'ha, core_exec_pkg::COND_ALWAYS, 9'h0), 32'h1, 32'h1);
		check("carry kept", {zeroFlag, carryFlag}, 2'b11);
		issue(mk(core_exec_pkg::OP_PLAIN_UCMP, 4'he, 4'h8, 9'h0), 32'h2, 32'h1);
		check("both set cond", {zeroFlag, carryFlag}, 2'b00);
		for (int k = 0; k < 8; k++) begin
			coreNumber = k[2:0];
			issue(mk(core_exec_pkg::OP_HUB, 4'hb, core_exec_pkg::COND_ALWAYS,
				{6'h0, core_exec_pkg::HUB_OWN_ID}), 32'h0, 32'h0);
			check("own id", {weSeen, destIdx, dataSeen}, {1'b1, 9'h005, k});
			check("own id zero", zeroFlag, (k == 0));
			check("own id clocks", (cyc >= 7 && cyc <= 22), 1);
		end
		coreNumber = 3'h0;
		issue(mk(core_exec_pkg::OP_HUB, 4'hb, 4'h0, {6'h0, core_exec_pkg::HUB_OWN_ID}), 32'h0, 32'h0);
		check("skipped hub", {weSeen, zeroFlag, cyc}, {2'b00, 32'h4});
		launch(opnd(1'b1, 3'h0), 3'h1, 1'b0, 1'b0);
		check("enables", coreClockEnable, 8'h03);
		launch(opnd(1'b0, 3'h0), 3'h0, 1'b1, 1'b0);
		halt(3'h1, 8'h01);
		for (int k = 1; k < 8; k++) begin
			launch(opnd(1'b1, 3'h0), k[2:0], 1'b0, 1'b0);
		end
		check("all enabled", coreClockEnable, 8'hff);
		launch(opnd(1'b1, 3'h0), core_exec_pkg::NO_FREE_ID, 1'b0, 1'b1);
		halt(3'h3, 8'hf7);
		launch(opnd(1'b1, 3'h0), 3'h3, 1'b0, 1'b0);
		check("refill", coreClockEnable, 8'hff);
		check("loads", {modelErrs, loadsDone}, {32'h0, 32'ha});
		// second reset in mid-run must bring the slice back to its idle state
		arst_n = 1'b0;
		@(posedge clk);
		#1;
		check("reset again", {zeroFlag, carryFlag, instrReady, loadValid, coreClockEnable}, 12'h201);
		arst_n = 1'b1;
		// chained zero must start from the cleared flag after reset
		issue(mk(core_exec_pkg::OP_EXT_UCMP, 4'he, core_exec_pkg::COND_ALWAYS, 9'h0), 32'h5, 32'h5);
		check("after reset", {weSeen, zeroFlag, carryFlag, cyc}, {3'b000, 32'h4});
		conclude();
	end
endmodule : tb_top
`default_nettype wire
